/* hw/bvcd_pkg.sv */
/*
  Constants and the state type of the buck channel voltage code decoder.
  Assumes a single core clock domain; shared by the decoder module and its testbench.
*/
package bvcd_pkg;

  // ----------------------------------------------------------------
  // Field widths
  // ----------------------------------------------------------------
  localparam int BVCD_SEL_W   = 6;
  localparam int BVCD_RANGE_W = 2;
  localparam int BVCD_VOLT_W  = 16;

  // ----------------------------------------------------------------
  // Range encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] BVCD_RANGE_FINE  = 2'h0;
  localparam logic [1:0] BVCD_RANGE_SHIFT = 2'h1;
  localparam logic [1:0] BVCD_RANGE_MID   = 2'h2;
  localparam logic [1:0] BVCD_RANGE_WIDE  = 2'h3;

  // ----------------------------------------------------------------
  // Voltages in units of 0.1 mV, and the all-ones and all-zeros select codes
  // ----------------------------------------------------------------
  localparam logic [15:0] BVCD_BASE_0V5   = 16'h1388; // 0.5 V
  localparam logic [15:0] BVCD_BASE_0V7   = 16'h1b58; // 0.7 V
  localparam logic [15:0] BVCD_STEP_12M5  = 16'h007d; // 12.5 mV
  localparam logic [15:0] BVCD_STEP_25M   = 16'h00fa; // 25 mV
  localparam logic [15:0] BVCD_STEP_50M   = 16'h01f4; // 50 mV
  localparam logic [15:0] BVCD_TOP_3V8    = 16'h9470; // 3.80 V
  localparam logic [5:0]  BVCD_SEL_ONES   = 6'h3f;
  localparam logic [5:0]  BVCD_SEL_ZEROS  = 6'h00;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] BVCD_RST_RANGE   = 2'h3;
  localparam logic [5:0] BVCD_RST_MAXSEL  = 6'h3f;
  localparam logic       BVCD_RST_SRC     = 1'b0;
  localparam logic [5:0] BVCD_RST_OPSEL   = 6'h00;
  localparam logic [5:0] BVCD_RST_AVSSEL  = 6'h00;

  // ----------------------------------------------------------------
  // State of the decoder
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] rangeSel;
    logic [5:0] maxSel;
    logic       sourceRegisterChoice;
    logic [5:0] opSel;
    logic [5:0] scaleSel;
  } bvcd_state_s;

endpackage

/* hw/bvcd_core.sv */
/*
  Buck channel voltage code decoder: holds range, limit, source choice
  and the two select codes, and decodes them into a target voltage.
  The target is an integer count of 0.1 mV for the analog reference.
  Assumes write strobes come from the serial control logic on core_clk,
  one cycle wide each, so no input needs a synchroniser here.
  Assumes the reference stage settles on its own; no ramping is done.
*/
`timescale 1ns/1ns
`default_nettype none

module bvcd_core
  import bvcd_pkg::*;
(
  // Clock and reset
  input  wire logic                          core_clk,
  input  wire logic                          rstn,
  // Operating register write
  input  wire logic                          opWrEn,
  input  wire logic                          opWrChoice,
  input  wire logic [bvcd_pkg::BVCD_SEL_W-1:0]   opWrSel,
  // Scaling register write
  input  wire logic                          scaleWrEn,
  input  wire logic [bvcd_pkg::BVCD_SEL_W-1:0]   scaleWrSel,
  // Limit register write
  input  wire logic                          limitWrEn,
  input  wire logic [bvcd_pkg::BVCD_RANGE_W-1:0] limitWrRange,
  input  wire logic [bvcd_pkg::BVCD_SEL_W-1:0]   limitWrMaxSel,
  // Status and result
  output logic                               limitLocked,
  output logic [bvcd_pkg::BVCD_SEL_W-1:0]        effectiveSel,
  output logic [bvcd_pkg::BVCD_VOLT_W-1:0]       buckOutputVoltage
);
  import bvcd_pkg::*;

  // Registered fields, their next value, and the code before the clamp
  bvcd_state_s state_ff;
  bvcd_state_s nxt_state;
  logic [5:0]  chosenSel;

  // ----------------------------------------------------------------
  // Decode function
  // ----------------------------------------------------------------
  // Exact integer table in 0.1 mV units
  // Half-millivolt steps stay whole numbers, so nothing is rounded
  // Wide range top code breaks the 50 mV pattern
  function automatic logic [15:0] decodeVolt(input logic [1:0] rng, input logic [5:0] sel);
    logic [15:0] code;
    code = {10'h000, sel};
    case (rng)
      BVCD_RANGE_FINE:  decodeVolt = 16'(BVCD_BASE_0V5 + code * BVCD_STEP_12M5);
      BVCD_RANGE_SHIFT: decodeVolt = 16'(BVCD_BASE_0V7 + code * BVCD_STEP_12M5);
      BVCD_RANGE_MID:   decodeVolt = 16'(BVCD_BASE_0V5 + code * BVCD_STEP_25M);
      default: begin
        if (sel == BVCD_SEL_ONES) begin
          decodeVolt = BVCD_TOP_3V8;
        end else begin
          decodeVolt = 16'(BVCD_BASE_0V5 + code * BVCD_STEP_50M);
        end
      end
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Register writes, limit writes refused while locked
  // Several strobes in one cycle touch separate fields, so all apply
  always_comb begin
    nxt_state = state_ff;
    if (opWrEn) begin
      nxt_state.sourceRegisterChoice = opWrChoice;
      nxt_state.opSel = opWrSel;
    end
    if (scaleWrEn) begin
      nxt_state.scaleSel = scaleWrSel;
    end
    if (limitWrEn && !limitLocked) begin
      nxt_state.rangeSel = limitWrRange;
      nxt_state.maxSel = limitWrMaxSel;
    end
  end

  // State register with synchronous reset
  // Power-on values open the limit so software can set it once
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      state_ff <= '{rangeSel: BVCD_RST_RANGE, maxSel: BVCD_RST_MAXSEL,
                    sourceRegisterChoice: BVCD_RST_SRC, opSel: BVCD_RST_OPSEL,
                    scaleSel: BVCD_RST_AVSSEL};
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Lock, source choice, clamp and decode
  // Lock looks at the stored limit, so the locking write itself lands
  // Clamp follows selection, so either source is held under the limit
  // A zero limit pins every code to the lowest step
  assign limitLocked = (state_ff.maxSel != BVCD_SEL_ZEROS) && (state_ff.maxSel != BVCD_SEL_ONES);
  assign chosenSel = state_ff.sourceRegisterChoice ? state_ff.scaleSel : state_ff.opSel;
  assign effectiveSel = (chosenSel > state_ff.maxSel) ? state_ff.maxSel : chosenSel;
  assign buckOutputVoltage = decodeVolt(state_ff.rangeSel, effectiveSel);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // All checks share the core clock and pause while reset is low

  // Decode table, one linear check per range
  a_fine_range_map: assert property (
    state_ff.rangeSel == 2'h0 |-> buckOutputVoltage == 16'(16'h1388 + effectiveSel * 16'h007d))
    else $error("fine range decode wrong");
  a_shift_range_map: assert property (
    state_ff.rangeSel == 2'h1 |-> buckOutputVoltage == 16'(16'h1b58 + effectiveSel * 16'h007d))
    else $error("shifted range decode wrong");
  a_mid_range_map: assert property (
    state_ff.rangeSel == 2'h2 |-> buckOutputVoltage == 16'(16'h1388 + effectiveSel * 16'h00fa))
    else $error("mid range decode wrong");
  a_wide_range_map: assert property (
    state_ff.rangeSel == 2'h3 && effectiveSel != 6'h3f
      |-> buckOutputVoltage == 16'(16'h1388 + effectiveSel * 16'h01f4))
    else $error("wide range decode wrong");

  // Fixed table points, middle and end of each range
  a_fine_top_code: assert property (
    state_ff.rangeSel == 2'h0 && effectiveSel == 6'h3f |-> buckOutputVoltage == 16'h324b)
    else $error("fine range top code wrong");
  a_shift_top_code: assert property (
    state_ff.rangeSel == 2'h1 && effectiveSel == 6'h3f |-> buckOutputVoltage == 16'h3a1b)
    else $error("shifted range top code wrong");
  a_shift_half_code: assert property (
    state_ff.rangeSel == 2'h1 && effectiveSel == 6'h20 |-> buckOutputVoltage == 16'h2af8)
    else $error("shifted range code 32 wrong");
  a_mid_top_code: assert property (
    state_ff.rangeSel == 2'h2 && effectiveSel == 6'h3f |-> buckOutputVoltage == 16'h510e)
    else $error("mid range top code wrong");
  a_mid_half_code: assert property (
    state_ff.rangeSel == 2'h2 && effectiveSel == 6'h20 |-> buckOutputVoltage == 16'h32c8)
    else $error("mid range code 32 wrong");
  a_wide_half_code: assert property (
    state_ff.rangeSel == 2'h3 && effectiveSel == 6'h20 |-> buckOutputVoltage == 16'h5208)
    else $error("wide range code 32 wrong");
  a_wide_below_top: assert property (
    state_ff.rangeSel == 2'h3 && effectiveSel == 6'h3e |-> buckOutputVoltage == 16'h8ca0)
    else $error("wide range code 62 wrong");
  a_wide_top_code: assert property (
    state_ff.rangeSel == 2'h3 && effectiveSel == 6'h3f |-> buckOutputVoltage == 16'h9470)
    else $error("wide range top code wrong");
  a_fine_mid_code: assert property (
    state_ff.rangeSel == 2'h0 && effectiveSel == 6'h20 |-> buckOutputVoltage == 16'h2328)
    else $error("fine range code 32 wrong");

  // Limit clamp
  a_limit_clamp: assert property (
    effectiveSel <= state_ff.maxSel
      && (chosenSel <= state_ff.maxSel ? effectiveSel == chosenSel : effectiveSel == state_ff.maxSel))
    else $error("limit clamp wrong");
  a_limit_zero: assert property (
    state_ff.maxSel == 6'h00 |-> effectiveSel == 6'h00)
    else $error("zero limit not applied");

  // Limit lock
  a_lock_holds: assert property (
    limitLocked && limitWrEn |=> $stable(state_ff.rangeSel) && $stable(state_ff.maxSel) && limitLocked)
    else $error("locked limit changed");
  a_unlock_write: assert property (
    !limitLocked && limitWrEn |=> state_ff.rangeSel == $past(limitWrRange) && state_ff.maxSel == $past(limitWrMaxSel))
    else $error("unlocked limit write lost");
  a_lock_open: assert property (
    (state_ff.maxSel == 6'h00 || state_ff.maxSel == 6'h3f) |-> !limitLocked)
    else $error("limit locked at open value");
  a_lock_closed: assert property (
    state_ff.maxSel != 6'h00 && state_ff.maxSel != 6'h3f |-> limitLocked)
    else $error("limit not locked");
  a_refused_volt: assert property (
    limitLocked && limitWrEn && !opWrEn && !scaleWrEn |=> $stable(buckOutputVoltage))
    else $error("refused limit write moved the target");

  // Source choice and select writes
  a_source_pick: assert property (
    opWrEn && opWrChoice |=> chosenSel == state_ff.scaleSel)
    else $error("source choice wrong");
  a_source_op: assert property (
    !state_ff.sourceRegisterChoice && state_ff.opSel <= state_ff.maxSel
      |-> effectiveSel == state_ff.opSel)
    else $error("operating code not used");
  a_source_scale: assert property (
    state_ff.sourceRegisterChoice && state_ff.scaleSel <= state_ff.maxSel
      |-> effectiveSel == state_ff.scaleSel)
    else $error("scaling code not used");
  a_op_write: assert property (
    opWrEn |=> state_ff.opSel == $past(opWrSel) && state_ff.sourceRegisterChoice == $past(opWrChoice))
    else $error("operating write lost");
  a_scale_write: assert property (
    scaleWrEn |=> state_ff.scaleSel == $past(scaleWrSel))
    else $error("scaling write lost");

  // Main scenarios reached
  c_lock_engaged: cover property (!limitLocked && limitWrEn ##1 limitLocked);
  c_clamp_active: cover property (chosenSel > state_ff.maxSel);
  c_wide_top: cover property (state_ff.rangeSel == 2'h3 && effectiveSel == 6'h3f);
  c_scale_source: cover property (state_ff.sourceRegisterChoice && scaleWrEn);
  c_zero_limit: cover property (state_ff.maxSel == 6'h00);

endmodule

`default_nettype wire

/* tb/test_buck_voltage_code_decoder.sv */
/*
  Self-checking bench for the buck channel voltage code decoder.
  Assumes the decoder package and core are compiled first; no partner model.
*/
`timescale 1ns/1ns
`default_nettype none

module test_buck_voltage_code_decoder;
  import bvcd_pkg::*;
  // ----------------------------------------------------------------
  // Signals and counters
  // ----------------------------------------------------------------
  logic        core_clk, rstn, opWrEn, opWrChoice, scaleWrEn, limitWrEn, limitLocked;
  logic [5:0]  opWrSel, scaleWrSel, limitWrMaxSel, effectiveSel;
  logic [1:0]  limitWrRange;
  logic [15:0] buckOutputVoltage;
  int          fails, compares, cycles;

  bvcd_core i_dut (.core_clk(core_clk), .rstn(rstn), .opWrEn(opWrEn), .opWrChoice(opWrChoice),
    .opWrSel(opWrSel), .scaleWrEn(scaleWrEn), .scaleWrSel(scaleWrSel), .limitWrEn(limitWrEn),
    .limitWrRange(limitWrRange), .limitWrMaxSel(limitWrMaxSel), .limitLocked(limitLocked),
    .effectiveSel(effectiveSel), .buckOutputVoltage(buckOutputVoltage));

  // ----------------------------------------------------------------
  // Clock and hang guard
  // ----------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 2000) begin
      fails++;
      report_and_stop();
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    if (fails == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One strobe cycle, strobes drop after the edge, then one idle edge
  task automatic step();
    @(posedge core_clk);
    #5;
    {opWrEn, scaleWrEn, limitWrEn} = 3'h0;
    @(posedge core_clk);
    #5;
  endtask
  task automatic wr_op(logic ch, logic [5:0] s);
    {opWrEn, opWrChoice, opWrSel} = {1'b1, ch, s};
    step();
  endtask
  task automatic wr_lim(logic [1:0] r, logic [5:0] m);
    {limitWrEn, limitWrRange, limitWrMaxSel} = {1'b1, r, m};
    step();
  endtask
  // Target in 0.1 mV from range and code
  function automatic logic [15:0] volt(logic [1:0] r, logic [5:0] s);
    case (r)
      2'h0: return 16'h1388 + 16'h007d * s;
      2'h1: return 16'h1b58 + 16'h007d * s;
      2'h2: return 16'h1388 + 16'h00fa * s;
      default: return (s == 6'h3f) ? 16'h9470 : 16'h1388 + 16'h01f4 * s;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic do_reset();
    rstn = 1'b0;
    repeat (8) @(posedge core_clk);
    #5;
    rstn = 1'b1;
  endtask
  // Every range and every code, unlocked limit
  task automatic sweep_table();
    for (int r = 0; r < 4; r++) begin
      wr_lim(r[1:0], 6'h3f);
      for (int s = 0; s < 64; s++) begin
        wr_op(1'b0, s[5:0]);
        check("volt", buckOutputVoltage, volt(r[1:0], s[5:0]));
      end
    end
    wr_lim(2'h0, 6'h3f);
    wr_op(1'b0, 6'h20);
    check("mid", buckOutputVoltage, 16'h2328);
  endtask
  // Source choice picks operating or scaling code
  task automatic source_choice();
    {scaleWrEn, scaleWrSel} = {1'b1, 6'h2a};
    wr_op(1'b1, 6'h05);
    check("sel scale", {10'h0, effectiveSel}, 16'h002a);
    wr_op(1'b0, 6'h05);
    check("sel op", {10'h0, effectiveSel}, 16'h0005);
  endtask
  // Clamp, lock, refused limit write, zero limit after reset
  task automatic clamp_lock();
    wr_lim(2'h0, 6'h10);
    wr_op(1'b0, 6'h20);
    check("clamp", {10'h0, effectiveSel}, 16'h0010);
    check("locked", {15'h0, limitLocked}, 16'h0001);
    wr_lim(2'h3, 6'h3f);
    check("refused", buckOutputVoltage, volt(2'h0, 6'h10));
    do_reset();
    check("rst volt", buckOutputVoltage, 16'h1388);
    wr_lim(2'h2, 6'h00);
    wr_op(1'b0, 6'h05);
    check("zero max", {9'h0, limitLocked, effectiveSel}, 16'h0000);
  endtask

  initial begin
    {opWrEn, opWrChoice, opWrSel, scaleWrEn, scaleWrSel} = '0;
    {limitWrEn, limitWrRange, limitWrMaxSel, fails, compares, cycles} = '0;
    do_reset();
    check("rst sel", {9'h0, limitLocked, effectiveSel}, 16'h0000);
    sweep_table();
    source_choice();
    clamp_lock();
    report_and_stop();
  end
endmodule

`default_nettype wire
